// >>> core/cadc_control.sv
// Converter control register, channel sequencer and result registers
// Functional notes
// - Control bit 7 enables conversions; zero keeps converter idle; resets to 0.
// - Control bit 6 picks continuous (0) or single pass (1); resets 0.
// - Bits 5..1 drop bus V, bus I, battery V, battery I, die temperature.
// - Single pass clears enable bit itself after all selected channels convert.
// - Control bit 0 and result high-byte bits 7..4 read zero.
// - Bus voltage result 12-bit, 4 mV per count, high nibble then low byte.
// - Bus current result 12-bit, 2 mA per count, high nibble and low byte.
// - Battery voltage result 12-bit, 2 mV per count, nibble and byte.
// - Battery current result 12-bit, 2 mA per count, nibble and byte.
// - Die temperature result is one unsigned byte, 1 degree per count.
// - Single pass sets done flag; read clears it; unmasked flag drives interrupt.
`default_nettype none
module cadc_control
    import cadc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    output logic conv_start,
    output logic [2:0] conv_channel,
    input wire cadc_pkg::cadc_sample_t sample,
    output logic adc_done_pulse,
    input wire logic done_mask,
    input wire logic done_flag_read,
    output logic done_flag,
    output logic interrupt_out_n,
    output logic converter_busy
);
    import cadc_pkg::*;

    cadc_ctrl_t ctrl_r;
    cadc_state_t state_r;
    logic [2:0] ch_r;
    logic [11:0] result_r [CADC_NUM_CH];
    logic done_r;
    logic [7:0] rd_data_r;
    logic clear_all;
    logic ctrl_wr;
    logic pass_end;
    logic sample_hit;
    logic [2:0] next_ch;
    logic any_on;
    logic [2:0] first_ch;

    assign clear_all = !rst_n || reg_reset;
    assign ctrl_wr = wr_en && (addr == CADC_OFF_CTRL);
    assign any_on = (ctrl_r.channel_off != 5'h1f);
    assign sample_hit = (state_r == CADC_CONV) && sample.valid && (sample.channel == ch_r);

    // Channel bit for index i is channel_off[4-i]
    always_comb begin
        next_ch = ch_r;
        pass_end = 1'b1;
        for (int i = CADC_NUM_CH - 1; i >= 0; i--) begin
            if (i > int'(ch_r) && !ctrl_r.channel_off[4 - i]) begin
                next_ch = 3'(i);
                pass_end = 1'b0;
            end
        end
        first_ch = 3'h0;
        for (int i = CADC_NUM_CH - 1; i >= 0; i--) begin
            if (!ctrl_r.channel_off[4 - i]) begin
                first_ch = 3'(i);
            end
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (clear_all) begin
            ctrl_r <= cadc_ctrl_t'(CADC_CTRL_RESET[7:1]);
        end else begin
            if (ctrl_wr) begin
                ctrl_r.one_shot <= wr_data[CADC_BIT_ONESHOT];
                ctrl_r.channel_off <= wr_data[5:1];
            end
            if (watchdog_expired) begin
                ctrl_r.en <= 1'b0;
            end else if (ctrl_wr) begin
                ctrl_r.en <= wr_data[CADC_BIT_EN];
            end else if (state_r == CADC_NEXT && pass_end && ctrl_r.one_shot) begin
                ctrl_r.en <= 1'b0;
            end
        end
    end

    // Sequencer: one channel at a time, restarts after each pass when continuous
    always_ff @(posedge clk) begin
        if (clear_all) begin
            state_r <= CADC_IDLE;
            ch_r <= CADC_CH_INPUT_BUS_VOLTAGE;
        end else begin
            case (state_r)
                CADC_IDLE: begin
                    if (ctrl_r.en && any_on) begin
                        state_r <= CADC_CONV;
                        ch_r <= first_ch;
                    end
                end
                CADC_CONV: begin
                    if (!ctrl_r.en) begin
                        state_r <= CADC_IDLE;
                    end else if (sample_hit) begin
                        state_r <= CADC_NEXT;
                    end
                end
                CADC_NEXT: begin
                    if (!ctrl_r.en || (pass_end && ctrl_r.one_shot)) begin
                        state_r <= CADC_IDLE;
                    end else if (pass_end) begin
                        state_r <= any_on ? CADC_CONV : CADC_IDLE;
                        ch_r <= first_ch;
                    end else begin
                        state_r <= CADC_CONV;
                        ch_r <= next_ch;
                    end
                end
                default: begin
                    state_r <= CADC_IDLE;
                end
            endcase
        end
    end

    // Whole 12-bit word latched at once; bus writes never reach these
    always_ff @(posedge clk) begin
        if (clear_all) begin
            for (int i = 0; i < CADC_NUM_CH; i++) begin
                result_r[i] <= CADC_RESULT_RESET;
            end
        end else if (sample_hit) begin
            if (ch_r == CADC_CH_DIE_TEMPERATURE) begin
                result_r[ch_r] <= {4'h0, sample.data[7:0]};
            end else begin
                result_r[ch_r] <= sample.data;
            end
        end
    end

    // Done flag; set beats a read clear in the same cycle
    always_ff @(posedge clk) begin
        if (clear_all) begin
            done_r <= 1'b0;
        end else if (state_r == CADC_NEXT && pass_end && ctrl_r.one_shot && ctrl_r.en) begin
            done_r <= 1'b1;
        end else if (done_flag_read) begin
            done_r <= 1'b0;
        end
    end

    // Registered read data
    always_ff @(posedge clk) begin
        if (clear_all) begin
            rd_data_r <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                CADC_OFF_CTRL: rd_data_r <= {ctrl_r, 1'b0};
                CADC_OFF_INPUT_BUS_VOLTAGE_HI: rd_data_r <= {4'h0, result_r[CADC_CH_INPUT_BUS_VOLTAGE][11:8]};
                CADC_OFF_INPUT_BUS_VOLTAGE_LO: rd_data_r <= result_r[CADC_CH_INPUT_BUS_VOLTAGE][7:0];
                CADC_OFF_INPUT_BUS_CURRENT_HI: rd_data_r <= {4'h0, result_r[CADC_CH_INPUT_BUS_CURRENT][11:8]};
                CADC_OFF_INPUT_BUS_CURRENT_LO: rd_data_r <= result_r[CADC_CH_INPUT_BUS_CURRENT][7:0];
                CADC_OFF_VBAT_HI: rd_data_r <= {4'h0, result_r[CADC_CH_VBAT][11:8]};
                CADC_OFF_VBAT_LO: rd_data_r <= result_r[CADC_CH_VBAT][7:0];
                CADC_OFF_BATTERY_CURRENT_HI: rd_data_r <= {4'h0, result_r[CADC_CH_BATTERY_CURRENT][11:8]};
                CADC_OFF_BATTERY_CURRENT_LO: rd_data_r <= result_r[CADC_CH_BATTERY_CURRENT][7:0];
                CADC_OFF_DIE_TEMPERATURE: rd_data_r <= result_r[CADC_CH_DIE_TEMPERATURE][7:0];
                default: rd_data_r <= 8'h00;
            endcase
        end
    end

    assign rd_data = rd_data_r;
    assign conv_start = (state_r == CADC_CONV);
    assign conv_channel = ch_r;
    assign adc_done_pulse = (state_r == CADC_NEXT) && pass_end && ctrl_r.one_shot && ctrl_r.en;
    assign done_flag = done_r;
    assign interrupt_out_n = !(done_r && !done_mask);
    assign converter_busy = (state_r != CADC_IDLE);
endmodule
`default_nettype wire

// >>> core/cadc_pkg.sv
// Package for the charger converter control and result block
`default_nettype none
package cadc_pkg;
    localparam logic [7:0] CADC_OFF_CTRL = 8'h11;
    localparam logic [7:0] CADC_OFF_INPUT_BUS_VOLTAGE_HI = 8'h12;
    localparam logic [7:0] CADC_OFF_INPUT_BUS_VOLTAGE_LO = 8'h13;
    localparam logic [7:0] CADC_OFF_INPUT_BUS_CURRENT_HI = 8'h14;
    localparam logic [7:0] CADC_OFF_INPUT_BUS_CURRENT_LO = 8'h15;
    localparam logic [7:0] CADC_OFF_VBAT_HI = 8'h16;
    localparam logic [7:0] CADC_OFF_VBAT_LO = 8'h17;
    localparam logic [7:0] CADC_OFF_BATTERY_CURRENT_HI = 8'h18;
    localparam logic [7:0] CADC_OFF_BATTERY_CURRENT_LO = 8'h19;
    localparam logic [7:0] CADC_OFF_DIE_TEMPERATURE = 8'h1a;
    localparam logic [7:0] CADC_CTRL_RESET = 8'h00;
    localparam logic [11:0] CADC_RESULT_RESET = 12'h000;
    localparam int CADC_BIT_EN = 7;
    localparam int CADC_BIT_ONESHOT = 6;
    localparam int CADC_NUM_CH = 5;
    // Channel index order matches control bits 5 down to 1
    localparam logic [2:0] CADC_CH_INPUT_BUS_VOLTAGE = 3'h0;
    localparam logic [2:0] CADC_CH_INPUT_BUS_CURRENT = 3'h1;
    localparam logic [2:0] CADC_CH_VBAT = 3'h2;
    localparam logic [2:0] CADC_CH_BATTERY_CURRENT = 3'h3;
    localparam logic [2:0] CADC_CH_DIE_TEMPERATURE = 3'h4;

    typedef struct packed {
        logic en;
        logic one_shot;
        logic [4:0] channel_off;
    } cadc_ctrl_t;

    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        logic [11:0] data;
    } cadc_sample_t;

    typedef enum logic [2:0] {
        CADC_IDLE = 3'b001,
        CADC_CONV = 3'b010,
        CADC_NEXT = 3'b100
    } cadc_state_t;
endpackage
`default_nettype wire

// >>> tb/cadc_control_sva.sv
// Assertion checker for the converter control block
`default_nettype none
module cadc_control_sva
    import cadc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_reset,
    input wire logic watchdog_expired,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] rd_data,
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    input wire cadc_pkg::cadc_sample_t sample,
    input wire logic adc_done_pulse,
    input wire logic done_mask,
    input wire logic done_flag_read,
    input wire logic done_flag,
    input wire logic interrupt_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || reg_reset);
    a_wd_stop: assert property (watchdog_expired |-> ##3 !conv_start)
        else $error("converting after watchdog");
    a_ctrl_bit0: assert property (rd_en && addr == 8'h11 |=> !rd_data[0])
        else $error("reserved control bit set");
    a_high_nibble: assert property (rd_en && addr inside {8'h12, 8'h14, 8'h16, 8'h18}
        |=> rd_data[7:4] == 4'h0) else $error("reserved result bits set");
    a_unmapped_zero: assert property (rd_en && (addr < 8'h11 || addr > 8'h1a)
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    a_sample_taken: assert property (conv_start && sample.valid
        && sample.channel == conv_channel |=> !conv_start) else $error("sample not taken");
    a_done_sets: assert property (adc_done_pulse && !done_flag_read |=> done_flag)
        else $error("done flag not set");
    a_flag_clear: assert property (done_flag_read && !adc_done_pulse |=> !done_flag)
        else $error("done flag not cleared");
    a_irq_level: assert property ((done_flag && !done_mask) [*2] |-> !interrupt_out_n)
        else $error("interrupt missing");
    a_irq_masked: assert property (done_mask [*2] |-> interrupt_out_n)
        else $error("masked interrupt seen");
    a_pass_ends: assert property (adc_done_pulse |=> !adc_done_pulse && !conv_start)
        else $error("single pass did not stop");
    cover property (adc_done_pulse);
    cover property (done_flag_read && done_flag);
    cover property (conv_start && sample.valid);
endmodule
bind cadc_control cadc_control_sva cadc_control_sva_inst (
    .clk(clk),
    .rst_n(rst_n),
    .reg_reset(reg_reset),
    .watchdog_expired(watchdog_expired),
    .rd_en(rd_en),
    .addr(addr),
    .rd_data(rd_data),
    .conv_start(conv_start),
    .conv_channel(conv_channel),
    .sample(sample),
    .adc_done_pulse(adc_done_pulse),
    .done_mask(done_mask),
    .done_flag_read(done_flag_read),
    .done_flag(done_flag),
    .interrupt_out_n(interrupt_out_n)
);
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the converter control block
`default_nettype none
module testbench;
    import cadc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, reg_reset = 0, watchdog_expired = 0, wr_en = 0, rd_en = 0;
    logic done_mask = 0, done_flag_read = 0, conv_start, adc_done_pulse, done_flag;
    logic interrupt_out_n, converter_busy;
    logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data;
    logic [2:0] conv_channel;
    cadc_sample_t sample = '0;
    int fail_count = 0, checks_done = 0, cycles = 0;
    cadc_control cadc_control_inst (
        .clk(clk),
        .rst_n(rst_n),
        .reg_reset(reg_reset),
        .watchdog_expired(watchdog_expired),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .addr(addr),
        .wr_data(wr_data),
        .rd_data(rd_data),
        .conv_start(conv_start),
        .conv_channel(conv_channel),
        .sample(sample),
        .adc_done_pulse(adc_done_pulse),
        .done_mask(done_mask),
        .done_flag_read(done_flag_read),
        .done_flag(done_flag),
        .interrupt_out_n(interrupt_out_n),
        .converter_busy(converter_busy)
    );
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {wr_en, addr, wr_data} = {1'b1, a, d};
        @(negedge clk);
        wr_en = 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        {rd_en, addr} = {1'b1, a};
        @(negedge clk);
        rd_en = 0;
        chk(rd_data, exp);
    endtask
    task automatic rd_table(input logic [7:0] ex [9]);
        for (int i = 0; i < 9; i++)
            rd(8'h12 + 8'(i), ex[i]);
    endtask
    // Released sample lines show the inverse so a stale value cannot match
    task automatic feed(input logic [2:0] ch, input logic [11:0] v);
        int n = 0;
        while (conv_start !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(conv_channel, ch);
        sample = '{1'b1, ch, v};
        @(negedge clk);
        sample = '{1'b0, ~ch, ~v};
    endtask
    task automatic t_reset_values();
        rd(CADC_OFF_CTRL, 8'h00);
        rd_table('{default: 8'h00});
        rd(8'h20, 8'h00);
        $display("reset values test done");
    endtask
    task automatic t_single();
        wr(CADC_OFF_CTRL, 8'hd3);
        feed(3'h0, 12'habc);
        feed(3'h2, 12'h5a5);
        feed(3'h3, 12'h3c7);
        repeat (2) @(negedge clk);
        chk(done_flag, 1'b1);
        chk(converter_busy, 1'b0);
        chk(interrupt_out_n, 1'b0);
        rd(CADC_OFF_CTRL, 8'h52);
        wr(8'h12, 8'hff);
        rd_table('{8'h0a, 8'hbc, 8'h00, 8'h00, 8'h05, 8'ha5, 8'h03, 8'hc7, 8'h00});
        done_mask = 1;
        @(negedge clk);
        chk(interrupt_out_n, 1'b1);
        {done_mask, done_flag_read} = 2'b01;
        @(negedge clk);
        done_flag_read = 0;
        chk(done_flag, 1'b0);
        $display("single pass test done");
    endtask
    task automatic t_continuous();
        wr(CADC_OFF_CTRL, 8'h84);
        feed(3'h0, 12'h001);
        feed(3'h1, 12'hfff);
        feed(3'h2, 12'h002);
        feed(3'h4, 12'h1a5);
        feed(3'h0, 12'h7ff);
        chk(converter_busy, 1'b1);
        watchdog_expired = 1;
        @(negedge clk);
        watchdog_expired = 0;
        repeat (3) @(negedge clk);
        chk(conv_start, 1'b0);
        rd(CADC_OFF_CTRL, 8'h04);
        rd_table('{8'h07, 8'hff, 8'h0f, 8'hff, 8'h00, 8'h02, 8'h03, 8'hc7, 8'ha5});
        // Host reads 125 degrees: code is the reading plus the forty degree offset
        rd(CADC_OFF_DIE_TEMPERATURE, 8'(125 + 40));
        chk(done_flag, 1'b0);
        $display("continuous test done");
    endtask
    task automatic t_reg_reset();
        reg_reset = 1;
        @(negedge clk);
        reg_reset = 0;
        t_reset_values();
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        t_reset_values();
        t_single();
        t_continuous();
        t_reg_reset();
        test_done();
    end
endmodule
`default_nettype wire
